// ### design/camera_stream_setup_regs.sv
// camera stream setup register bank with selected transmit settings
`timescale 1ns/1ps
`include "stream_setup_defs.svh"

// Functional notes
// - the active format comes from the top three bits of the format register, codes 0,1,2,6,7.
// - legacy mode sends on the channel held in the four-bit legacy channel field.
// - legacy speed is a two-bit code for 100, 200 or 400 Mbit/s.
// - one mode bit picks legacy (0) or 1394b (1) and so which channel and speed fields apply.
// - 1394b mode sends on the channel held in the six-bit 1394b channel field.
// - 1394b speed is a three-bit code for 100 Mbit/s up to 3.2 Gbit/s.
// - the continuous bit starts or stops free-run transmission only under format 0 or 7.
// - writing one to the save bit copies the working settings to the chosen channel, then clears.
// - bit 0 of each register is its most significant bit, offsets are bytes from the base.
// - the save-channel register keeps a four-bit channel number in its top bits.
module camera_stream_setup_regs (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register access port
    input  wire logic [11:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [31:0] reg_wdata,
    output logic [31:0]      reg_rdata,
    output logic             reg_ack,
    output logic             reg_err,
    // selected transmit settings
    output logic [2:0]       video_format,
    output logic [5:0]       tx_channel,
    output logic [2:0]       tx_speed,
    output logic             op_mode_b,
    output logic             free_run_active,
    // settings memory write port
    output logic             mem_we,
    output logic [3:0]       mem_chan,
    output logic [31:0]      mem_data
);
    // stored fields
    logic [2:0] fmt;
    logic [3:0] ch_legacy;
    logic [1:0] sp_legacy;
    stream_setup_pkg::op_mode_e op_mode;
    logic [5:0] ch_b;
    logic [2:0] sp_b;
    logic       run_req;
    logic       save_pend;
    logic [3:0] save_chan;

    // sequencer links
    logic       store_busy;
    logic       store_done;
    logic       store_we;
    logic [3:0] store_chan;
    logic [31:0] store_data;

    // address decode
    wire hit_fmt   = (reg_addr == `OFS_VIDEO_FORMAT);
    wire hit_cfg   = (reg_addr == `OFS_STREAM_CFG);
    wire hit_run   = (reg_addr == `OFS_FREE_RUN);
    wire hit_save  = (reg_addr == `OFS_STORE_TRIG);
    wire hit_schan = (reg_addr == `OFS_STORE_CHAN);
    wire hit_any   = hit_fmt | hit_cfg | hit_run | hit_save | hit_schan;

    // format code legal check, used for format register writes
    function automatic logic fmt_legal(input logic [2:0] f);
        fmt_legal = (f == `FMT_0) || (f == `FMT_1) || (f == `FMT_2) ||
                    (f == `FMT_6) || (f == `FMT_7);
    endfunction

    // msb-first layout of each register image
    wire [31:0] img_fmt = {fmt, 29'h0};
    wire [31:0] img_cfg = {ch_legacy, 2'h0, sp_legacy, 8'h00,
                           (op_mode == stream_setup_pkg::OP_B), 1'b0,
                           ch_b, 5'h00, sp_b};
    wire [31:0] img_run = {run_req, 31'h0};
    wire [31:0] img_save = {save_pend, 31'h0};
    wire [31:0] img_schan = {save_chan, 28'h0};

    // unmapped and reserved bits read zero
    wire [31:0] rd_mux = hit_fmt   ? img_fmt :
                         hit_cfg   ? img_cfg :
                         hit_run   ? img_run :
                         hit_save  ? img_save :
                         hit_schan ? img_schan : 32'h0000_0000;

    wire [2:0] w_fmt  = reg_wdata[`FMT_HI:`FMT_LO];
    wire [1:0] w_spl  = reg_wdata[`SPL_HI:`SPL_LO];
    wire [2:0] w_spb  = reg_wdata[`SPB_HI:`SPB_LO];
    wire       wr_cfg = reg_wr & hit_cfg;

    wire fmt_we = reg_wr & hit_fmt & fmt_legal(w_fmt);
    // run effective only under format 0 or 7
    wire run_ok = (fmt == `FMT_0) || (fmt == `FMT_7);
    wire save_start = reg_wr & hit_save & reg_wdata[`SAVE_BIT] & ~save_pend
                      & ~store_busy;
    wire is_b = (op_mode == stream_setup_pkg::OP_B);

    always_ff @(posedge clk) begin
        if (rst) begin
            fmt <= `RST_FMT;
        end else if (fmt_we) begin
            fmt <= w_fmt;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ch_legacy <= `RST_CH4;
            sp_legacy <= `RST_SPL;
            op_mode   <= stream_setup_pkg::OP_LEGACY;
            ch_b      <= `RST_CH6;
            sp_b      <= `RST_SPB;
        end else if (wr_cfg) begin
            ch_legacy <= reg_wdata[`CHL_HI:`CHL_LO];
            if (w_spl <= `SPL_MAX) sp_legacy <= w_spl;
            op_mode <= reg_wdata[`OPMODE_BIT] ? stream_setup_pkg::OP_B
                                              : stream_setup_pkg::OP_LEGACY;
            ch_b <= reg_wdata[`CHB_HI:`CHB_LO];
            if (w_spb <= `SPB_MAX) sp_b <= w_spb;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            run_req   <= 1'b0;
            save_chan <= `RST_CH4;
        end else begin
            if (reg_wr & hit_run) run_req <= reg_wdata[`RUN_BIT];
            if (reg_wr & hit_schan) save_chan <= reg_wdata[`SCH_HI:`SCH_LO];
        end
    end

    // save bit self clears when copy completes
    always_ff @(posedge clk) begin
        if (rst) begin
            save_pend <= 1'b0;
        end else if (save_start) begin
            save_pend <= 1'b1;
        end else if (store_done) begin
            save_pend <= 1'b0;
        end
    end

    settings_store u_store (
        .clk      (clk),
        .rst      (rst),
        .start    (save_start),
        .channel  (save_chan),
        .work_cfg (img_cfg),
        .mem_we   (store_we),
        .mem_chan (store_chan),
        .mem_data (store_data),
        .busy     (store_busy),
        .done     (store_done)
    );

    // registered outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata       <= 32'h0000_0000;
            reg_ack         <= 1'b0;
            reg_err         <= 1'b0;
            video_format    <= `RST_FMT;
            tx_channel      <= `RST_CH6;
            tx_speed        <= `RST_SPB;
            op_mode_b       <= 1'b0;
            free_run_active <= 1'b0;
            mem_we          <= 1'b0;
            mem_chan        <= `RST_CH4;
            mem_data        <= 32'h0000_0000;
        end else begin
            reg_rdata       <= reg_rd ? rd_mux : 32'h0000_0000;
            reg_ack         <= (reg_rd | reg_wr) & hit_any;
            reg_err         <= (reg_rd | reg_wr) & ~hit_any;
            video_format    <= fmt;
            // mode picks the channel and speed in force
            tx_channel      <= is_b ? ch_b : {2'h0, ch_legacy};
            tx_speed        <= is_b ? sp_b : {1'b0, sp_legacy};
            op_mode_b       <= is_b;
            free_run_active <= run_req & run_ok;
            mem_we          <= store_we;
            mem_chan        <= store_chan;
            mem_data        <= store_data;
        end
    end
endmodule

// ### design/stream_setup_defs.svh
// offsets, field positions and codes for the stream setup register bank
`ifndef STREAM_SETUP_DEFS_SVH
`define STREAM_SETUP_DEFS_SVH

// register byte offsets from the bank base
`define OFS_VIDEO_FORMAT   12'h608
`define OFS_STREAM_CFG     12'h60c
`define OFS_FREE_RUN       12'h614
`define OFS_STORE_TRIG     12'h618
`define OFS_STORE_CHAN     12'h620

// field positions in verilog bit order (bit 0 of the map is bit 31 here)
`define FMT_HI             31
`define FMT_LO             29
`define CHL_HI             31
`define CHL_LO             28
`define SPL_HI             25
`define SPL_LO             24
`define OPMODE_BIT         15
`define CHB_HI             13
`define CHB_LO             8
`define SPB_HI             2
`define SPB_LO             0
`define RUN_BIT            31
`define SAVE_BIT           31
`define SCH_HI             31
`define SCH_LO             28

// video format codes
`define FMT_0              3'h0
`define FMT_1              3'h1
`define FMT_2              3'h2
`define FMT_6              3'h6
`define FMT_7              3'h7

// speed code limits
`define SPL_MAX            2'h2
`define SPB_MAX            3'h5

// reset values
`define RST_FMT            3'h0
`define RST_CH4            4'h0
`define RST_SPL            2'h0
`define RST_CH6            6'h00
`define RST_SPB            3'h0

`endif

// ### design/stream_setup_pkg.sv
// types shared by the stream setup register bank
package stream_setup_pkg;
    typedef enum logic {
        OP_LEGACY,
        OP_B
    } op_mode_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_COPY,
        ST_DONE
    } store_state_e;
endpackage

// ### design/settings_store.sv
// store sequencer: copies the working settings into a memory channel
`timescale 1ns/1ps
`include "stream_setup_defs.svh"

module settings_store (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // request and target
    input  wire logic        start,
    input  wire logic [3:0]  channel,
    input  wire logic [31:0] work_cfg,
    // memory write port
    output logic             mem_we,
    output logic [3:0]       mem_chan,
    output logic [31:0]      mem_data,
    // status
    output logic             busy,
    output logic             done
);
    stream_setup_pkg::store_state_e state;
    stream_setup_pkg::store_state_e next_state;

    always_comb begin
        next_state = state;
        case (state)
            stream_setup_pkg::ST_IDLE:
                if (start) next_state = stream_setup_pkg::ST_COPY;
            stream_setup_pkg::ST_COPY: next_state = stream_setup_pkg::ST_DONE;
            stream_setup_pkg::ST_DONE: next_state = stream_setup_pkg::ST_IDLE;
            default: next_state = stream_setup_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state    <= stream_setup_pkg::ST_IDLE;
            mem_we   <= 1'b0;
            mem_chan <= `RST_CH4;
            mem_data <= 32'h0000_0000;
            done     <= 1'b0;
        end else begin
            state  <= next_state;
            mem_we <= (state == stream_setup_pkg::ST_COPY);
            done   <= (state == stream_setup_pkg::ST_DONE);
            // snapshot target and settings when a save starts
            if (state == stream_setup_pkg::ST_IDLE && start) begin
                mem_chan <= channel;
                mem_data <= work_cfg;
            end
        end
    end

    assign busy = (state != stream_setup_pkg::ST_IDLE);
endmodule

// ### tb/camera_stream_setup_regs_props.sv
// port assertions for the stream setup register bank
`timescale 1ns/1ps
`include "stream_setup_defs.svh"
module stream_setup_props (
    // watched ports
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [11:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        reg_ack,
    input wire logic        reg_err,
    input wire logic [2:0]  video_format,
    input wire logic [5:0]  tx_channel,
    input wire logic [2:0]  tx_speed,
    input wire logic        op_mode_b,
    input wire logic        free_run_active,
    input wire logic        mem_we,
    input wire logic [3:0]  mem_chan,
    input wire logic [31:0] mem_data
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire hit = reg_addr inside {`OFS_VIDEO_FORMAT, `OFS_STREAM_CFG,
        `OFS_FREE_RUN, `OFS_STORE_TRIG, `OFS_STORE_CHAN};
    wire req = reg_wr | reg_rd;
    wire cfg = reg_wr && reg_addr == `OFS_STREAM_CFG;
    wire fmt = reg_wr && reg_addr == `OFS_VIDEO_FORMAT;
    wire save = reg_wr && reg_addr == `OFS_STORE_TRIG && reg_wdata[31];
    AST_ACK: assert property (
        req && hit |=> reg_ack && !reg_err) else $error("no ack");
    AST_ERR: assert property (
        req && !hit |=> reg_err && !reg_ack && reg_rdata == 32'h0)
        else $error("unmapped access not refused");
    AST_FMT: assert property (
        fmt && reg_wdata[31:29] inside {0, 1, 2, 6, 7} |-> ##2
        {video_format, 29'h0} == ($past(reg_wdata, 2) & 32'he0000000))
        else $error("format not taken");
    AST_LEG: assert property (
        cfg && !reg_wdata[15] && reg_wdata[25:24] != 2'h3 |-> ##2
        tx_channel[5:4] == 2'h0 && !tx_speed[2] && !op_mode_b &&
        {tx_channel[3:0], 2'h0, tx_speed[1:0], 24'h0}
        == ($past(reg_wdata, 2) & 32'hf3000000)) else $error("legacy set");
    AST_MB: assert property (
        cfg && reg_wdata[15] && reg_wdata[2:0] <= 3'h5 |-> ##2 op_mode_b
        && {18'h0, tx_channel, 5'h0, tx_speed}
        == ($past(reg_wdata, 2) & 32'h3f07)) else $error("b mode set");
    AST_RUN: assert property (
        free_run_active |-> video_format inside {0, 7})
        else $error("free run under wrong format");
    AST_SAVE: assert property (
        mem_we |-> $past(save, 3)) else $error("store without request");
    AST_PULSE: assert property (
        mem_we |=> !mem_we) else $error("store pulse too long");
    AST_RSV: assert property (
        reg_ack && $past(reg_rd) && $past(reg_addr) == `OFS_FREE_RUN
        |-> reg_rdata[30:0] == 31'h0) else $error("reserved bits set");
endmodule

bind camera_stream_setup_regs stream_setup_props i_props (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_ack(reg_ack), .reg_err(reg_err), .video_format(video_format),
    .tx_channel(tx_channel), .tx_speed(tx_speed), .op_mode_b(op_mode_b),
    .free_run_active(free_run_active), .mem_we(mem_we),
    .mem_chan(mem_chan), .mem_data(mem_data));

// ### tb/camera_stream_setup_regs_test.sv
// self-checking bench for the stream setup register bank
`timescale 1ns/1ps
`include "stream_setup_defs.svh"
module camera_stream_setup_regs_test;
    logic        clk, rst, reg_wr, reg_rd, reg_ack, reg_err;
    logic        op_mode_b, free_run_active, mem_we;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, mem_data, sv_data;
    logic [2:0]  video_format, tx_speed;
    logic [5:0]  tx_channel;
    logic [3:0]  mem_chan, sv_chan;
    int          miscompares = 0, samples_checked = 0, cycles = 0, saves;

    camera_stream_setup_regs i_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_ack(reg_ack), .reg_err(reg_err), .video_format(video_format),
        .tx_channel(tx_channel), .tx_speed(tx_speed), .op_mode_b(op_mode_b),
        .free_run_active(free_run_active), .mem_we(mem_we),
        .mem_chan(mem_chan), .mem_data(mem_data));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one strobe cycle, returns once the answer has settled
    task automatic access(logic is_wr, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= is_wr;
        reg_rd <= !is_wr;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] d);
        access(1'b1, a, d);
        check("ack", reg_ack, 1);
    endtask

    task automatic rd(logic [11:0] a, logic [31:0] exp);
        access(1'b0, a, 0);
        check("rdata", reg_rdata, exp);
    endtask

    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    task automatic t_reset;
        logic [11:0] ofs [5] = '{`OFS_VIDEO_FORMAT, `OFS_STREAM_CFG,
            `OFS_FREE_RUN, `OFS_STORE_TRIG, `OFS_STORE_CHAN};
        foreach (ofs[i]) rd(ofs[i], 0);
        check("mode", op_mode_b, 0);
    endtask

    task automatic t_format;
        logic [2:0] cur = 3'h0;
        for (int c = 0; c < 8; c++) begin
            wr(`OFS_VIDEO_FORMAT, {c[2:0], 29'h1fffffff});
            if (c inside {0, 1, 2, 6, 7}) cur = c[2:0];
            settle;
            check("format", video_format, cur);
            rd(`OFS_VIDEO_FORMAT, {cur, 29'h0});
        end
    endtask

    task automatic t_chan_speed;
        wr(`OFS_STREAM_CFG, 32'hfeff7ffd);
        settle;
        check("chan", tx_channel, 6'h0f);
        check("speed", tx_speed, 3'h2);
        check("mode", op_mode_b, 0);
        rd(`OFS_STREAM_CFG, 32'hf2003f05);
        wr(`OFS_STREAM_CFG, 32'h13000000);
        settle;
        check("chan", tx_channel, 6'h01);
        check("speed", tx_speed, 3'h2);
        wr(`OFS_STREAM_CFG, 32'h0000bf06);
        settle;
        check("mode", op_mode_b, 1);
        check("chan", tx_channel, 6'h3f);
        check("speed", tx_speed, 3'h0);
        wr(`OFS_STREAM_CFG, 32'h0000a505);
        settle;
        check("chan", tx_channel, 6'h25);
        check("speed", tx_speed, 3'h5);
    endtask

    task automatic t_free_run;
        logic [11:0] a [4] = '{`OFS_FREE_RUN, `OFS_VIDEO_FORMAT,
            `OFS_VIDEO_FORMAT, `OFS_FREE_RUN};
        logic [31:0] d [4] = '{32'hffffffff, 32'h20000000, 0, 32'h7fffffff};
        logic        e [4] = '{1, 0, 1, 0};
        foreach (a[i]) begin
            wr(a[i], d[i]);
            settle;
            check("free run", free_run_active, e[i]);
        end
        rd(`OFS_FREE_RUN, 0);
    endtask

    task automatic t_save;
        wr(`OFS_STORE_CHAN, 32'h9fffffff);
        rd(`OFS_STORE_CHAN, 32'h90000000);
        saves = 0;
        wr(`OFS_STORE_TRIG, 32'hffffffff);
        wr(`OFS_STORE_TRIG, 32'h80000000);
        repeat (8) settle;
        check("saves", saves, 1);
        check("mem chan", sv_chan, 4'h9);
        check("mem data", sv_data, 32'h0000a505);
        rd(`OFS_STORE_TRIG, 0);
    endtask

    task automatic t_unmapped;
        access(1'b1, 12'h610, 32'hffffffff);
        check("err", reg_err, 1);
        access(1'b0, 12'h610, 0);
        check("err", reg_err, 1);
        check("rdata", reg_rdata, 0);
    endtask

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (mem_we === 1'b1) begin
            saves++;
            sv_chan = mem_chan;
            sv_data = mem_data;
        end
        if (cycles == 3000) begin
            miscompares++;
            tally_and_finish;
        end
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 12'h000;
        reg_wdata = 32'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        t_format;
        t_chan_speed;
        t_free_run;
        t_save;
        t_unmapped;
        tally_and_finish;
    end
endmodule
